// ==== dv/imdu_asserts.sv ====
// Purpose: Timing checks on the multiply/divide unit ports.
// Assumes: One clock, active-low asynchronous reset.
// Notes: Bound to the unit's top module.
`default_nettype none
module imdu_asserts import imdu_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire issue_req_t i_req,
  input wire logic o_accept,
  input wire logic o_accept_gpr,
  input wire logic o_stall,
  input wire logic o_acc_busy,
  input wire gpr_wb_t o_gpr,
  input wire logic [63:0] o_upper_accumulator,
  input wire logic [63:0] o_bottom_accumulator
);
  wire op_t op = i_req.op;
  wire [16:0] hb = i_req.source_b_reg[31:15];
  wire shs = (&hb) | ~(|hb);
  wire sgn = op inside {signed_product_op, accumulate_signed_op};
  wire acc_op = op inside {accumulate_signed_op, accumulate_unsigned_op};
  wire wd = sgn || acc_op || op == unsigned_product_op;
  wire shrt = sgn ? shs : ~(|hb);
  wire dwm = op inside {dword_signed_product, dword_unsigned_product};
  wire dvw = op inside {signed_quotient_op, unsigned_quotient_op};
  wire dvd = op inside {dword_signed_quotient, dword_unsigned_quotient};
  wire take = i_req.valid && o_accept && op != product_to_gpr_op;
  wire take_g = i_req.valid && o_accept_gpr && op == product_to_gpr_op;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Accept reopens one cycle after the closing cycles
  sequence s_reopen; !o_accept ##1 o_accept; endsequence
  property p_rep_short; take && wd && shrt |=> s_reopen; endproperty
  a_rep_short: assert property (p_rep_short) else $error("short repeat");
  property p_rep_long; take && wd && !shrt |=> !o_accept ##1 s_reopen; endproperty
  a_rep_long: assert property (p_rep_long) else $error("long repeat");
  property p_rep_dw; take && dwm |=> !o_accept[*3] ##1 s_reopen; endproperty
  a_rep_dw: assert property (p_rep_dw) else $error("dword repeat");
  property p_rep_div; take && dvw |=> ##34 s_reopen; endproperty
  a_rep_div: assert property (p_rep_div) else $error("divide repeat");
  property p_rep_dword_signed_quotient; take && dvd |=> ##66 s_reopen; endproperty
  a_rep_dword_signed_quotient: assert property (p_rep_dword_signed_quotient) else $error("dword divide repeat");
  property p_stall_l; take_g && !shs |=> o_stall[*2] ##1 !o_stall; endproperty
  a_stall_l: assert property (p_stall_l) else $error("stall length");
  property p_gpr_lat; take_g && shs |-> ##3 o_gpr.valid ##1 !o_gpr.valid; endproperty
  a_gpr_lat: assert property (p_gpr_lat) else $error("gpr latency");
  property p_acc_gpr; take && acc_op |=> !o_accept_gpr[*2]; endproperty
  a_acc_gpr: assert property (p_acc_gpr) else $error("extra repeat");
  property p_busy; take && wd && shrt |=> o_acc_busy[*2]; endproperty
  a_busy: assert property (p_busy) else $error("busy interlock");
endmodule
bind integer_multiply_divide_unit imdu_asserts chk_i (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_req(i_req), .o_accept(o_accept), .o_accept_gpr(o_accept_gpr), .o_stall(o_stall),
  .o_acc_busy(o_acc_busy), .o_gpr(o_gpr), .o_upper_accumulator(o_upper_accumulator),
  .o_bottom_accumulator(o_bottom_accumulator));
`default_nettype wire

// ==== dv/pipeline_model.sv ====
// Purpose: Issue side of the integer pipeline.
// Assumes: Tasks start just after a rising edge.
// Notes: A released request shows inverted operands.
`default_nettype none
module pipeline_model import imdu_pkg::*; (
  input wire logic i_clk,
  input wire logic i_accept,
  input wire logic i_accept_gpr,
  output var issue_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_req = '0;
  task automatic issue(input op_t op, input logic [63:0] a, input logic [63:0] b);
    o_req <= '{1'b1, op, a, b};
    @(negedge i_clk);
    while ((op == product_to_gpr_op ? i_accept_gpr : i_accept) !== 1'b1) begin
      @(negedge i_clk);
    end
    @(posedge i_clk);
  endtask
  task automatic idle();
    o_req <= '{1'b0, o_req.op, ~o_req.source_a_reg, ~o_req.source_b_reg};
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the multiply/divide unit.
// Assumes: 20 MHz clock, active-low reset.
// Notes: Most timing figures are left to the checker.
`default_nettype none
module testbench import imdu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {op_t op; logic [63:0] a, b, up, bo;} row_t;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  issue_req_t req;
  logic acc, acc_g, stall, busy;
  gpr_wb_t gpr;
  logic [63:0] up, bo;
  int miscompares = 0;
  int checks = 0;
  int n;
  time t0;
  row_t rows [11] = '{
    '{signed_product_op, -64'h3, 64'h7, -64'h1, -64'h15},
    '{accumulate_signed_op, 64'h10000, 64'h10000, 64'h0, -64'h15},
    '{accumulate_unsigned_op, 64'hA_FFFFFFFF, 64'hFFFFFFFF, -64'h2, -64'h14},
    '{accumulate_unsigned_op, 64'h4, 64'h40000005, 64'h0, 64'h0},
    '{unsigned_product_op, 64'hFFFFFFFF, 64'h7FFF, 64'h7FFE, -64'h7FFF},
    '{dword_signed_product, -64'h2, 64'h3, -64'h1, -64'h6},
    '{dword_unsigned_product, 64'h8000000000000000, 64'h4, 64'h2, 64'h0},
    '{signed_quotient_op, -64'h7, 64'h2, -64'h1, -64'h3},
    '{unsigned_quotient_op, 64'hFFFFFFFF, 64'h10, 64'hF, 64'hFFFFFFF},
    '{dword_signed_quotient, -64'h64, 64'h7, -64'h2, -64'hE},
    '{dword_unsigned_quotient, 64'h64, 64'h7, 64'h2, 64'hE}};
  integer_multiply_divide_unit dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req),
    .o_accept(acc), .o_accept_gpr(acc_g), .o_stall(stall), .o_acc_busy(busy),
    .o_gpr(gpr), .o_upper_accumulator(up), .o_bottom_accumulator(bo));
  pipeline_model pm (.i_clk(i_clk), .i_accept(acc), .i_accept_gpr(acc_g), .o_req(req));
  initial forever #25 i_clk = ~i_clk;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Waits until the result has landed in the accumulators
  task automatic settle();
    n = 0;
    @(negedge i_clk);
    while (busy !== 1'b0 && n < 80) begin
      @(negedge i_clk);
      n++;
    end
    chk(busy, 64'h0);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    foreach (rows[i]) begin
      pm.issue(rows[i].op, rows[i].a, rows[i].b);
      pm.idle();
      settle();
      chk(up, rows[i].up);
      chk(bo, rows[i].bo);
      @(posedge i_clk);
    end
    pm.issue(signed_product_op, 64'h3, 64'h5);
    t0 = $time;
    pm.issue(accumulate_signed_op, 64'h3, 64'h5);
    chk(($time - t0) / 50, 64'h2);
    t0 = $time;
    pm.issue(product_to_gpr_op, -64'h2, 64'h10000);
    chk(($time - t0) / 50, 64'h3);
    pm.idle();
    n = 0;
    while (gpr.valid !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk(n, 64'h4);
    chk(gpr.data, -64'h20000);
    chk(bo, 64'h1E);
    @(posedge i_clk);
    pm.issue(product_to_gpr_op, 64'h7, -64'h8000);
    pm.idle();
    @(negedge i_clk);
    chk(stall, 64'h1);
    @(negedge i_clk);
    chk(stall, 64'h0);
    @(negedge i_clk);
    chk(gpr.valid, 64'h1);
    chk(gpr.data, -64'h38000);
    @(posedge i_clk);
    pm.issue(signed_quotient_op, 64'h9, 64'h2);
    pm.idle();
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b0;
    @(negedge i_clk);
    chk({acc, acc_g, stall, busy, gpr.valid}, 64'h18);
    chk(up | bo, 64'h0);
    final_report();
  end
  initial begin
    repeat (4000) @(posedge i_clk);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire

// ==== rtl/imdu_params.svh ====
// Purpose: Constants of the integer multiply/divide unit.
// Assumes: Counts are in core clock cycles.
// Notes: Included by the package and the design modules.
//
// Behaviour
// - Signed accumulate adds the signed 32x32 product to the 64-bit upper/bottom pair.
// - Unsigned accumulate zero-extends sources; each half is written sign-extended.
// - Accumulate overflow raises nothing; the wrapped sum is written back.
// - Product-to-register writes the low 32 product bits, sign-extended, to the register.
// - Product-to-register leaves the accumulators unchanged.
// - Signed multiply/accumulate with 16-bit second source: latency 3, repeat 2.
// - Signed multiply/accumulate with wider second source: latency 4, repeat 3.
// - Unsigned multiply/accumulate with second source below 2^15: latency 3, repeat 2.
// - Unsigned multiply/accumulate with larger second source: latency 4, repeat 3.
// - Product-to-register stalls for its latency minus two cycles.
// - Doubleword multiplies take latency 6, repeat 5.
// - Word divides take latency 36, repeat 36.
// - Doubleword divides take latency 68, repeat 68.
// - Accumulate directly followed by product-to-register adds one repeat cycle.
// - Accumulator moves see the result from the cycle after retirement; o_acc_busy is high until then.
`ifndef IMDU_PARAMS_SVH
`define IMDU_PARAMS_SVH

`define IMDU_CNT_W 7
`define IMDU_LAT_SHORT 7'h03
`define IMDU_REP_SHORT 7'h02
`define IMDU_LAT_LONG 7'h04
`define IMDU_REP_LONG 7'h03
`define IMDU_LAT_DW_MUL 7'h06
`define IMDU_REP_DW_MUL 7'h05
`define IMDU_LAT_DIV_W 7'h24
`define IMDU_REP_DIV_W 7'h24
`define IMDU_LAT_DIV_DW 7'h44
`define IMDU_REP_DIV_DW 7'h44
`define IMDU_STALL_SLACK 7'h02
`define IMDU_SHORT_POS 15
`define IMDU_ACC_RST 64'h0000_0000_0000_0000

`endif

// ==== rtl/imdu_pkg.sv ====
// Purpose: Types of the integer multiply/divide unit.
// Assumes: Constants come from imdu_params.svh.
// Notes: Requests and answers travel as packed structs.
`default_nettype none
`include "imdu_params.svh"
package imdu_pkg;
  typedef logic [`IMDU_CNT_W-1:0] cnt_t;

  typedef enum logic [3:0] {
    signed_product_op,
    unsigned_product_op,
    accumulate_signed_op,
    accumulate_unsigned_op,
    product_to_gpr_op,
    dword_signed_product,
    dword_unsigned_product,
    signed_quotient_op,
    unsigned_quotient_op,
    dword_signed_quotient,
    dword_unsigned_quotient
  } op_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic [63:0] source_a_reg;
    logic [63:0] source_b_reg;
  } issue_req_t;

  typedef struct packed {
    logic valid;
    logic [63:0] data;
  } gpr_wb_t;
endpackage
`default_nettype wire

// ==== rtl/imdu_timing.sv ====
// Purpose: Latency, repeat and stall figures per operation and operand range.
// Assumes: Second source value valid with the opcode.
// Notes: Purely combinational.
`default_nettype none
`include "imdu_params.svh"
module imdu_timing import imdu_pkg::*; (
  input wire op_t i_op,
  input wire logic [63:0] i_source_b_reg,
  output logic [`IMDU_CNT_W-1:0] o_lat,
  output logic [`IMDU_CNT_W-1:0] o_rep,
  output logic [`IMDU_CNT_W-1:0] o_stall
);
  wire logic [31:0] b_w = i_source_b_reg[31:0];
  wire logic signed_short = (b_w[31:`IMDU_SHORT_POS] == '0) ||
                            (b_w[31:`IMDU_SHORT_POS] == '1);
  wire logic unsigned_short = (b_w[31:`IMDU_SHORT_POS] == '0);
  wire logic is_unsigned = (i_op == unsigned_product_op) || (i_op == accumulate_unsigned_op);
  wire logic short_w = is_unsigned ? unsigned_short : signed_short;
  wire logic [`IMDU_CNT_W-1:0] lat_w = short_w ? `IMDU_LAT_SHORT : `IMDU_LAT_LONG;

  // Short word multiplies wide word multiplies
  assign o_lat = (i_op == dword_signed_product || i_op == dword_unsigned_product) ?
                 `IMDU_LAT_DW_MUL :
                 (i_op == signed_quotient_op || i_op == unsigned_quotient_op) ?
                 `IMDU_LAT_DIV_W :
                 (i_op == dword_signed_quotient || i_op == dword_unsigned_quotient) ?
                 `IMDU_LAT_DIV_DW : lat_w;
  assign o_rep = (i_op == dword_signed_product || i_op == dword_unsigned_product) ?
                 `IMDU_REP_DW_MUL :
                 (i_op == signed_quotient_op || i_op == unsigned_quotient_op) ?
                 `IMDU_REP_DIV_W :
                 (i_op == dword_signed_quotient || i_op == dword_unsigned_quotient) ?
                 `IMDU_REP_DIV_DW :
                 (short_w ? `IMDU_REP_SHORT : `IMDU_REP_LONG);
  // Stall all but two cycles of the latency
  assign o_stall = (i_op == product_to_gpr_op) ? lat_w - `IMDU_STALL_SLACK : '0;
endmodule
`default_nettype wire

// ==== rtl/integer_multiply_divide_unit.sv ====
// Purpose: Integer multiply, multiply-accumulate and divide unit with accumulator pair.
// Assumes: Pipeline issues only while the matching accept output is high.
// Notes: Accumulate sums are formed at retirement so back-to-back ops chain.
`default_nettype none
`include "imdu_params.svh"
module integer_multiply_divide_unit import imdu_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire issue_req_t i_req,
  output logic o_accept,
  output logic o_accept_gpr,
  output logic o_stall,
  output logic o_acc_busy,
  output var gpr_wb_t o_gpr,
  output logic [63:0] o_upper_accumulator,
  output logic [63:0] o_bottom_accumulator
);
  function automatic logic [63:0] sx32(input logic [31:0] v);
    sx32 = {{32{v[31]}}, v};
  endfunction

  // Upper and bottom halves, each sign-extended from its own bit 31
  function automatic logic [127:0] word_pair(input logic [63:0] v);
    word_pair = {sx32(v[63:32]), sx32(v[31:0])};
  endfunction

  function automatic logic is_acc_op(input op_t op);
    is_acc_op = (op == accumulate_signed_op) || (op == accumulate_unsigned_op);
  endfunction

  // Countdown that stops at zero
  function automatic cnt_t dec_sat(input cnt_t v);
    dec_sat = (v != '0) ? v - `IMDU_CNT_W'(1) : '0;
  endfunction

  // Divides; a zero divisor gives an all-ones quotient and the dividend as remainder
  function automatic logic [127:0] quotient(input op_t op, input logic [63:0] a,
                                            input logic [63:0] b);
    logic [31:0] q32;
    logic [31:0] r32;
    logic [63:0] q64;
    logic [63:0] r64;
    q32 = '1;
    r32 = a[31:0];
    q64 = '1;
    r64 = a;
    case (op)
      signed_quotient_op: begin
        if (b[31:0] != 32'h0000_0000) begin
          q32 = 32'($signed(a[31:0]) / $signed(b[31:0]));
          r32 = 32'($signed(a[31:0]) % $signed(b[31:0]));
        end
        quotient = word_pair({r32, q32});
      end
      unsigned_quotient_op: begin
        if (b[31:0] != 32'h0000_0000) begin
          q32 = a[31:0] / b[31:0];
          r32 = a[31:0] % b[31:0];
        end
        quotient = word_pair({r32, q32});
      end
      dword_signed_quotient: begin
        if (b != 64'h0) begin
          q64 = 64'($signed(a) / $signed(b));
          r64 = 64'($signed(a) % $signed(b));
        end
        quotient = {r64, q64};
      end
      dword_unsigned_quotient: begin
        if (b != 64'h0) begin
          q64 = a / b;
          r64 = a % b;
        end
        quotient = {r64, q64};
      end
      default: begin
        quotient = '0;
      end
    endcase
  endfunction

  function automatic logic [127:0] compute(input op_t op, input logic [63:0] a,
                                           input logic [63:0] b);
    logic [63:0] p32s;
    logic [63:0] p32u;
    logic [127:0] p64s;
    logic [127:0] p64u;
    p32s = $signed({{32{a[31]}}, a[31:0]}) * $signed({{32{b[31]}}, b[31:0]});
    p32u = {32'h0000_0000, a[31:0]} * {32'h0000_0000, b[31:0]};
    p64s = 128'($signed({{64{a[63]}}, a}) * $signed({{64{b[63]}}, b}));
    p64u = 128'({64'h0, a} * {64'h0, b});
    case (op)
      signed_product_op, accumulate_signed_op, product_to_gpr_op: begin
        compute = word_pair(p32s);
      end
      unsigned_product_op, accumulate_unsigned_op: begin
        compute = word_pair(p32u);
      end
      dword_signed_product: begin
        compute = p64s;
      end
      dword_unsigned_product: begin
        compute = p64u;
      end
      default: begin
        compute = quotient(op, a, b);
      end
    endcase
  endfunction

  logic [`IMDU_CNT_W-1:0] lat_q, rep_q, stall_q;
  logic extra_q;
  op_t pend_op_q;
  logic [127:0] pend_res_q;

  wire logic [`IMDU_CNT_W-1:0] tm_lat;
  wire logic [`IMDU_CNT_W-1:0] tm_rep;
  wire logic [`IMDU_CNT_W-1:0] tm_stall;

  imdu_timing u_timing (
    .i_op(i_req.op),
    .i_source_b_reg(i_req.source_b_reg),
    .o_lat(tm_lat),
    .o_rep(tm_rep),
    .o_stall(tm_stall)
  );

  // Operation classes of the request and of the pending result
  wire logic is_gpr = (i_req.op == product_to_gpr_op);
  wire logic is_acc = is_acc_op(i_req.op);
  // Early issue is refused by the accept flags
  wire logic take = i_req.valid && (is_gpr ? o_accept_gpr : o_accept);
  wire logic retire = (lat_q == `IMDU_CNT_W'(1));
  wire logic pend_acc = is_acc_op(pend_op_q);
  wire logic pend_gpr = (pend_op_q == product_to_gpr_op);
  wire logic gpr_done = retire && pend_gpr;
  // Product-to-register leaves the pair as it was
  wire logic pair_write = retire && !pend_gpr;

  // Full 64-bit word product, rebuilt from the two sign-extended halves
  wire logic [63:0] pend_prod = {pend_res_q[95:64], pend_res_q[31:0]};
  // Pair used as one 64-bit accumulator, wrapping silently
  wire logic [63:0] pair_now = {o_upper_accumulator[31:0], o_bottom_accumulator[31:0]};
  wire logic [63:0] acc_sum = pair_now + pend_prod;
  wire logic [127:0] acc_pair = word_pair(acc_sum);
  wire logic [63:0] hi_new = pend_acc ? acc_pair[127:64] : pend_res_q[127:64];
  wire logic [63:0] lo_new = pend_acc ? acc_pair[63:0] : pend_res_q[63:0];

  // Countdown counters and the issue flags derived from them
  wire logic [`IMDU_CNT_W-1:0] lat_d = take ? tm_lat - `IMDU_CNT_W'(1) : dec_sat(lat_q);
  wire logic [`IMDU_CNT_W-1:0] rep_d = take ? tm_rep - `IMDU_CNT_W'(1) : dec_sat(rep_q);
  wire logic [`IMDU_CNT_W-1:0] stall_d = (take && is_gpr) ? tm_stall : dec_sat(stall_q);
  // One more repeat cycle for a product-to-register behind an accumulate
  wire logic extra_d = take ? is_acc : (extra_q && (rep_q != '0));
  wire logic accept_d = (rep_d == '0);
  wire logic accept_gpr_d = accept_d && !extra_d;
  wire logic stall_flag_d = (stall_d != '0);
  wire logic busy_d = (lat_d != '0);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lat_q <= '0;
      rep_q <= '0;
      stall_q <= '0;
      extra_q <= 1'b0;
    end else begin
      lat_q <= lat_d;
      rep_q <= rep_d;
      stall_q <= stall_d;
      extra_q <= extra_d;
    end
  end

  // Issue flags go out straight from flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_accept <= 1'b1;
      o_accept_gpr <= 1'b1;
      o_stall <= 1'b0;
      o_acc_busy <= 1'b0;
    end else begin
      o_accept <= accept_d;
      o_accept_gpr <= accept_gpr_d;
      o_stall <= stall_flag_d;
      o_acc_busy <= busy_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_op_q <= signed_product_op;
      pend_res_q <= '0;
    end else if (take) begin
      pend_op_q <= i_req.op;
      pend_res_q <= compute(i_req.op, i_req.source_a_reg, i_req.source_b_reg);
    end
  end

  // Register write-back pulse, data held until the next one
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gpr <= '0;
    end else begin
      o_gpr.valid <= gpr_done;
      if (gpr_done) begin
        o_gpr.data <= sx32(pend_res_q[31:0]);
      end
    end
  end

  // Accumulators are flops, readable the cycle after retirement
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_upper_accumulator <= `IMDU_ACC_RST;
      o_bottom_accumulator <= `IMDU_ACC_RST;
    end else if (pair_write) begin
      o_upper_accumulator <= hi_new;
      o_bottom_accumulator <= lo_new;
    end
  end
endmodule
`default_nettype wire
